// File: hw/eipm_pkg.sv
// package: constants for the external interrupt and power mode controller
package eipm_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses on the ahb-lite slave)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PIN_IRQ_EN = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] PIN_IRQ_EN_RST = 8'h00;

	// status word field positions
	localparam int ST_MODE_LSB = 0;
	localparam int ST_IMASK = 4;
	localparam int ST_EXT_PEND = 5;
	localparam int ST_IRQ_REQ = 6;

	// ----------------------------------------------------------------
	// external line edge sensitivity (bit i is ext_line_(i+1))
	// ----------------------------------------------------------------
	localparam logic [7:0] EXT_RISE_LINES = 8'h33;
	localparam logic [7:0] EXT_FALL_LINES = 8'hCC;

	// ----------------------------------------------------------------
	// clocking and timing
	// ----------------------------------------------------------------
	localparam int OSC_TO_CPU_DIV = 3;
	localparam int STAB_CPU_CYCLES = 4096;
	localparam logic [12:0] STAB_LAST = 13'(STAB_CPU_CYCLES - 1);

	// ----------------------------------------------------------------
	// request sources, highest priority first
	// ----------------------------------------------------------------
	localparam int SRC_N = 7;
	localparam logic [2:0] SRC_TRAP = 3'h0;
	localparam logic [2:0] SRC_USB_SUSP = 3'h1;
	localparam logic [2:0] SRC_EXT = 3'h2;
	localparam logic [2:0] SRC_TIMER = 3'h3;
	localparam logic [2:0] SRC_I2C = 3'h4;
	localparam logic [2:0] SRC_SCI = 3'h5;
	localparam logic [2:0] SRC_USB = 3'h6;

	// vector addresses
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP = 16'hFFFC;
	localparam logic [15:0] VEC_USB_SUSP = 16'hFFFA;
	localparam logic [15:0] VEC_EXT = 16'hFFF8;
	localparam logic [15:0] VEC_TIMER = 16'hFFF6;
	localparam logic [15:0] VEC_I2C = 16'hFFF4;
	localparam logic [15:0] VEC_SCI = 16'hFFF2;
	localparam logic [15:0] VEC_USB = 16'hFFF0;

	// ----------------------------------------------------------------
	// power modes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		EIPM_RUN = 4'b0001,
		EIPM_WAIT = 4'b0010,
		EIPM_HALT = 4'b0100,
		EIPM_STAB = 4'b1000
	} eipm_mode_t;

endpackage : eipm_pkg

// File: hw/eipm_prio.sv
// module: fixed-priority selector for pending interrupt sources
`timescale 1ns/1ns
module eipm_prio
	import eipm_pkg::*;
(
	input wire logic [eipm_pkg::SRC_N-1:0] req,
	output logic any,
	output logic [2:0] idx,
	output logic [15:0] vec
);

	// ----------------------------------------------------------------
	// vector lookup
	// ----------------------------------------------------------------
	function automatic logic [15:0] eipm_vec(input logic [2:0] i);
		unique case (i)
			SRC_TRAP: eipm_vec = VEC_TRAP;
			SRC_USB_SUSP: eipm_vec = VEC_USB_SUSP;
			SRC_EXT: eipm_vec = VEC_EXT;
			SRC_TIMER: eipm_vec = VEC_TIMER;
			SRC_I2C: eipm_vec = VEC_I2C;
			SRC_SCI: eipm_vec = VEC_SCI;
			default: eipm_vec = VEC_USB;
		endcase
	endfunction : eipm_vec

	// ----------------------------------------------------------------
	// select lowest index set, index 0 is highest priority
	// ----------------------------------------------------------------
	// scan downward so the last hit is the highest priority one
	always_comb begin
		any = |req;
		idx = SRC_USB;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 3'(i);
			end
		end
		vec = eipm_vec(idx);
	end

endmodule : eipm_prio

// File: hw/eipm_ctrl.sv
// module: external pin interrupts, vectoring and wait/deep-stop control
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module eipm_ctrl
	import eipm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// port side
	input wire logic [7:0] ext_pin,
	input wire logic [7:0] ext_pin_is_output,
	// peripheral request levels
	input wire logic usb_susp_end_irq,
	input wire logic timer_irq,
	input wire logic i2c_irq,
	input wire logic sci_irq,
	input wire logic usb_irq,
	// cpu core side
	input wire logic trap_instr,
	input wire logic halt_instr,
	input wire logic wait_for_interrupt_instr,
	input wire logic mask_set,
	input wire logic mask_clr,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [15:0] irq_vector,
	output logic imask,
	output logic cpu_run,
	output logic periph_run,
	output logic osc_on
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		eipm_mode_t mode;
		logic imask;
		logic [7:0] pin_irq_enable_reg;
		logic [7:0] pin_prev;
		logic ext_pend;
		logic trap_pend;
		logic [12:0] stab_cnt;
		logic [15:0] vec;
		logic dph_wr;
		logic [7:0] dph_addr;
		logic [31:0] rdata;
	} eipm_state_t;

	eipm_state_t st_r;
	eipm_state_t st_nxt;

	logic [7:0] pin_edge;
	logic [SRC_N-1:0] src_raw;
	logic [SRC_N-1:0] src_ok;
	logic grant_any;
	logic [2:0] grant_idx;
	logic [15:0] grant_vec;
	logic take;
	logic halt_wake;
	logic addr_ok;

	// ----------------------------------------------------------------
	// pin edge detection
	// ----------------------------------------------------------------
	// output pins and disabled pins are cut off before edge checking
	always_comb begin
		pin_edge = st_r.pin_irq_enable_reg & ~ext_pin_is_output
			& ((EXT_RISE_LINES & ext_pin & ~st_r.pin_prev)
			| (EXT_FALL_LINES & ~ext_pin & st_r.pin_prev));
	end

	// ----------------------------------------------------------------
	// request sources and priority
	// ----------------------------------------------------------------
	// trap ignores the mask, the others are maskable
	always_comb begin
		src_raw = '0;
		src_raw[SRC_TRAP] = st_r.trap_pend;
		src_raw[SRC_USB_SUSP] = usb_susp_end_irq;
		src_raw[SRC_EXT] = st_r.ext_pend;
		src_raw[SRC_TIMER] = timer_irq;
		src_raw[SRC_I2C] = i2c_irq;
		src_raw[SRC_SCI] = sci_irq;
		src_raw[SRC_USB] = usb_irq;
		src_ok = src_raw;
		if (st_r.imask) begin
			src_ok = src_raw & 7'(1 << SRC_TRAP);
		end
	end

	eipm_prio u_prio (
		.req(src_ok),
		.any(grant_any),
		.idx(grant_idx),
		.vec(grant_vec)
	);

	// only pin and suspend-end events may restart the oscillator
	assign halt_wake = st_r.ext_pend | usb_susp_end_irq;
	assign irq_req = (st_r.mode == EIPM_RUN) & grant_any;
	assign take = irq_req & irq_ack;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign addr_ok = hsel & hready & htrans[1];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.pin_prev = ext_pin;

		// pin latch: a new edge wins over the acknowledge clear
		if (take && grant_idx == SRC_EXT) begin
			st_nxt.ext_pend = 1'b0;
		end
		if (|pin_edge) begin
			st_nxt.ext_pend = 1'b1;
		end

		if (take && grant_idx == SRC_TRAP) begin
			st_nxt.trap_pend = 1'b0;
		end
		if (trap_instr) begin
			st_nxt.trap_pend = 1'b1;
		end

		// cpu mask control, interrupt entry sets it over set/clear; halt and wait entry clear it after
		if (mask_clr) begin
			st_nxt.imask = 1'b0;
		end
		if (mask_set) begin
			st_nxt.imask = 1'b1;
		end
		if (take) begin
			st_nxt.imask = 1'b1;
			st_nxt.vec = grant_vec;
		end

		// power mode sequencing
		unique case (st_r.mode)
			EIPM_RUN: begin
				if (halt_instr) begin
					st_nxt.mode = EIPM_HALT;
					st_nxt.imask = 1'b0;
				end else if (wait_for_interrupt_instr) begin
					st_nxt.mode = EIPM_WAIT;
					st_nxt.imask = 1'b0;
				end
			end
			EIPM_WAIT: begin
				st_nxt.imask = 1'b0;
				if (|src_raw) begin
					st_nxt.mode = EIPM_RUN;
				end
			end
			EIPM_HALT: begin
				st_nxt.imask = 1'b0;
				st_nxt.stab_cnt = '0;
				if (halt_wake) begin
					st_nxt.mode = EIPM_STAB;
				end
			end
			EIPM_STAB: begin
				st_nxt.imask = 1'b0;
				st_nxt.stab_cnt = st_r.stab_cnt + 13'h0001;
				if (st_r.stab_cnt == STAB_LAST) begin
					st_nxt.mode = EIPM_RUN;
				end
			end
		endcase

		// ahb data phase write
		if (st_r.dph_wr && st_r.dph_addr == ADDR_PIN_IRQ_EN) begin
			st_nxt.pin_irq_enable_reg = hwdata[7:0];
		end
		// upper address bits must be zero, as for reads, so nothing aliases
		st_nxt.dph_wr = addr_ok & hwrite & (haddr[31:8] == 24'h000000);
		if (addr_ok) begin
			st_nxt.dph_addr = haddr[7:0];
		end

		// read data prepared in the address phase; a write still in its
		// data phase is forwarded so a back-to-back read sees the new value
		st_nxt.rdata = '0;
		if (addr_ok && !hwrite) begin
			if (haddr[31:0] == {24'h000000, ADDR_PIN_IRQ_EN}) begin
				st_nxt.rdata = {24'h000000, st_nxt.pin_irq_enable_reg};
			end else if (haddr[31:0] == {24'h000000, ADDR_STATUS}) begin
				st_nxt.rdata[ST_MODE_LSB +: 4] = st_r.mode;
				st_nxt.rdata[ST_IMASK] = st_r.imask;
				st_nxt.rdata[ST_EXT_PEND] = st_r.ext_pend;
				st_nxt.rdata[ST_IRQ_REQ] = irq_req;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// mask is set at reset so no maskable source is taken before software opens it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r.mode <= EIPM_RUN;
			st_r.imask <= 1'b1;
			st_r.pin_irq_enable_reg <= PIN_IRQ_EN_RST;
			st_r.pin_prev <= 8'h00;
			st_r.ext_pend <= 1'b0;
			st_r.trap_pend <= 1'b0;
			st_r.stab_cnt <= 13'h0000;
			st_r.vec <= VEC_RESET;
			st_r.dph_wr <= 1'b0;
			st_r.dph_addr <= 8'h00;
			st_r.rdata <= 32'h00000000;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// single-cycle slave: every transfer is zero-wait and okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_r.rdata;
	assign irq_vector = st_r.vec;
	assign imask = st_r.imask;
	assign cpu_run = (st_r.mode == EIPM_RUN);
	assign periph_run = (st_r.mode == EIPM_RUN) | (st_r.mode == EIPM_WAIT);
	// oscillator runs during stabilization, off only in deep stop
	assign osc_on = (st_r.mode != EIPM_HALT);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic [12:0] stab_seen;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stab_seen <= 13'h0000;
		end else if (st_r.mode == EIPM_STAB) begin
			stab_seen <= stab_seen + 13'h0001;
		end else begin
			stab_seen <= 13'h0000;
		end
	end

	a_rise_latch: assert property (
		(st_r.pin_irq_enable_reg[0] && !ext_pin_is_output[0]
			&& ext_pin[0] && !st_r.pin_prev[0]) |=> st_r.ext_pend)
		else $error("rising edge on line 1 not latched");

	a_fall_latch: assert property (
		(st_r.pin_irq_enable_reg[2] && !ext_pin_is_output[2]
			&& !ext_pin[2] && st_r.pin_prev[2]) |=> st_r.ext_pend)
		else $error("falling edge on line 3 not latched");

	a_output_silent: assert property (
		((ext_pin_is_output | ~st_r.pin_irq_enable_reg) == 8'hFF
			&& !st_r.ext_pend) |=> !st_r.ext_pend)
		else $error("output pin raised a request");

	a_halt_unmask: assert property (
		(st_r.mode == EIPM_RUN && halt_instr)
			|=> (st_r.mode == EIPM_HALT && !st_r.imask && !osc_on))
		else $error("deep stop entry wrong");

	a_halt_wake_src: assert property (
		(st_r.mode == EIPM_HALT && !st_r.ext_pend && !usb_susp_end_irq)
			|=> st_r.mode == EIPM_HALT)
		else $error("deep stop left without a waking source");

	a_stab_length: assert property (
		(st_r.mode == EIPM_STAB) |-> (!cpu_run && stab_seen <= STAB_LAST))
		else $error("stabilization longer than allowed");

	a_stab_exit: assert property (
		($past(st_r.mode) == EIPM_STAB && st_r.mode == EIPM_RUN)
			|-> $past(stab_seen) == STAB_LAST)
		else $error("stabilization not exactly 4096 cycles");

	a_wait_mask: assert property (
		(st_r.mode == EIPM_WAIT) |-> (!st_r.imask && periph_run && !cpu_run))
		else $error("wait mode mask or clocks wrong");

	a_wait_exit: assert property (
		(st_r.mode == EIPM_WAIT && timer_irq) |=> st_r.mode == EIPM_RUN)
		else $error("interrupt did not end wait");

	a_take_masks: assert property (
		take |=> (st_r.imask && irq_vector == $past(grant_vec)))
		else $error("interrupt entry did not mask");

	a_mask_blocks: assert property (
		(st_r.imask && !st_r.trap_pend) |-> !irq_req)
		else $error("masked request delivered");

	// grant test held in a net so the property stays short
	logic irq_vector_pick_trap;
	assign irq_vector_pick_trap = (grant_vec == VEC_TRAP);

	a_trap_first: assert property (
		(irq_req && st_r.trap_pend) |-> irq_vector_pick_trap)
		else $error("trap not highest priority");

endmodule : eipm_ctrl

// File: dv/eipm_cpu_model.sv
// cpu core stand-in: takes an offered interrupt after a set delay
`timescale 1ns/1ns
module eipm_cpu_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ack_en,
	input wire logic [3:0] ack_dly,
	input wire logic irq_req,
	output logic irq_ack
);
	typedef struct packed {
		logic [3:0] cnt;
		logic ack;
	} eipm_cpu_st_t;
	eipm_cpu_st_t st_r;
	eipm_cpu_st_t st_nxt;

	// ack only while an offer stands, so a late ack is never wasted
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		if (!st_r.ack && irq_req && ack_en) begin
			if (st_r.cnt == ack_dly)
				st_nxt.ack = 1'b1;
			else
				st_nxt.cnt = st_r.cnt + 4'h1;
		end
		if (st_nxt.ack || !irq_req)
			st_nxt.cnt = 4'h0;
	end

	// state register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign irq_ack = st_r.ack;
endmodule : eipm_cpu_model

// File: dv/tb_top.sv
// testbench: scenarios for the interrupt and power mode controller
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
	import eipm_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] pin = '0;
	logic [7:0] pin_out = '0;
	logic [4:0] lv = '0;
	logic [4:0] op = '0;
	logic ack_en = 1'b0;
	logic [3:0] ack_dly = '0;
	logic hreadyout, hresp, irq_ack, irq_req, imask;
	logic cpu_run, periph_run, osc_on;
	logic [15:0] irq_vector;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;

	// ----------------------------------------------------------------
	// design, cpu partner, clock and watchdog
	// ----------------------------------------------------------------
	eipm_ctrl dut (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.ext_pin(pin), .ext_pin_is_output(pin_out),
		.usb_susp_end_irq(lv[0]), .timer_irq(lv[1]), .i2c_irq(lv[2]),
		.sci_irq(lv[3]), .usb_irq(lv[4]), .trap_instr(op[0]),
		.halt_instr(op[1]), .wait_for_interrupt_instr(op[2]),
		.mask_set(op[3]), .mask_clr(op[4]), .irq_ack, .irq_req,
		.irq_vector, .imask, .cpu_run, .periph_run, .osc_on);
	eipm_cpu_model cpu (.ref_clk, .resetn, .ack_en, .ack_dly, .irq_req,
		.irq_ack);

	always #5 ref_clk = ~ref_clk;

	// a hang counts as a mismatch and ends the run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	// single word transfer; read data taken at the data phase's end edge
	task automatic ahb(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask : ahb

	// op bits: trap, halt, wait, mask set, mask clear
	task automatic pulse(input int b);
		@(posedge ref_clk);
		op <= 5'h1 << b;
		@(posedge ref_clk);
		op <= 5'h0;
	endtask : pulse

	// set one pin's level and direction, then check the request three cycles later
	task automatic to(input logic v, input logic o, input logic x,
		input int i);
		@(posedge ref_clk);
		pin[i] <= v;
		pin_out[i] <= o;
		repeat (3) @(posedge ref_clk);
		`CHK(irq_req, x);
	endtask : to

	// let the cpu take the offer; called at an edge with the mask clear
	task automatic take(input logic [15:0] v);
		ack_en <= 1'b1;
		for (int n = 0; n < 30 && imask !== 1'b1; n++) @(posedge ref_clk);
		ack_en <= 1'b0;
		`CHK(irq_vector, v);
	endtask : take

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		ahb(ADDR_PIN_IRQ_EN, 1'b0, '0, d);
		`CHK(d, 32'h0);
		ahb(ADDR_STATUS, 1'b0, '0, d);
		`CHK(d, 32'h11);
		`CHK({cpu_run, periph_run, osc_on, irq_vector}, 19'h7FFFE);
		`CHK({hreadyout, hresp}, 2'h2);
		pulse(4);
		@(negedge ref_clk);
		`CHK(imask, 1'b0);
		pulse(3);
		@(negedge ref_clk);
		`CHK(imask, 1'b1);
		ahb(ADDR_PIN_IRQ_EN, 1'b1, 32'hFFFFFFA5, d);
		ahb(8'h10, 1'b1, 32'hFF, d);
		ahb(ADDR_PIN_IRQ_EN, 1'b0, '0, d);
		`CHK(d, 32'hA5);
		ahb(8'h10, 1'b0, '0, d);
		`CHK(d, 32'h0);
		ahb(ADDR_PIN_IRQ_EN, 1'b1, 32'h0, d);
	endtask : t_regs

	// per line: disabled edges, wrong edge, output pin, then a request
	task automatic t_edges();
		logic [31:0] d;
		logic e;
		for (int i = 0; i < 8; i++) begin
			e = EXT_RISE_LINES[i];
			pulse(4);
			to(~e, 1'b0, 1'b0, i);
			to(e, 1'b0, 1'b0, i);
			ahb(ADDR_PIN_IRQ_EN, 1'b1, 32'h1 << i, d);
			to(~e, 1'b0, 1'b0, i);
			to(e, 1'b1, 1'b0, i);
			to(~e, 1'b0, 1'b0, i);
			to(e, 1'b0, 1'b1, i);
			take(VEC_EXT);
		end
	endtask : t_edges

	// masked pin event is latched, then sources drain in priority order
	task automatic t_prio();
		logic [31:0] d;
		logic [15:0] vq [6] = '{VEC_USB_SUSP, VEC_EXT, VEC_TIMER, VEC_I2C,
			VEC_SCI, VEC_USB};
		ack_dly <= 4'h3;
		ahb(ADDR_PIN_IRQ_EN, 1'b1, 32'h1, d);
		to(1'b0, 1'b0, 1'b0, 0);
		to(1'b1, 1'b0, 1'b0, 0);
		ahb(ADDR_STATUS, 1'b0, '0, d);
		`CHK(d, 32'h31);
		lv <= 5'h1F;
		for (int k = 0; k < 6; k++) begin
			pulse(4);
			@(posedge ref_clk);
			take(vq[k]);
			if (k != 1)
				lv[k ? k - 1 : 0] <= 1'b0;
		end
		ack_dly <= 4'h0;
		pulse(0);
		@(negedge ref_clk);
		`CHK(irq_req, 1'b1);
		@(posedge ref_clk);
		ack_en <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ack_en <= 1'b0;
		`CHK(irq_vector, VEC_TRAP);
	endtask : t_prio

	task automatic t_wait();
		pulse(2);
		@(negedge ref_clk);
		`CHK({cpu_run, periph_run, osc_on, imask}, 4'h6);
		pulse(3);
		repeat (5) @(posedge ref_clk);
		`CHK({cpu_run, imask}, 2'h0);
		lv[1] <= 1'b1;
		take(VEC_TIMER);
		lv[1] <= 1'b0;
	endtask : t_wait

	// deep stop ignores other sources; wake costs the full restart delay
	task automatic t_halt(input int s);
		int n = 0;
		pulse(1);
		@(negedge ref_clk);
		`CHK({cpu_run, periph_run, osc_on, imask}, 4'h0);
		@(posedge ref_clk);
		lv[1] <= 1'b1;
		lv[3] <= 1'b1;
		pin[0] <= 1'b0;
		repeat (20) @(posedge ref_clk);
		`CHK(osc_on, 1'b0);
		if (s == 0)
			pin[0] <= 1'b1;
		else
			lv[0] <= 1'b1;
		repeat (5000) begin
			@(posedge ref_clk);
			if (cpu_run === 1'b1)
				break;
			n += int'(osc_on === 1'b1);
		end
		`CHK(n, STAB_CPU_CYCLES);
		take(s ? VEC_USB_SUSP : VEC_EXT);
		lv <= '0;
	endtask : t_halt

	// reset ends deep stop and restores the register
	task automatic t_reset();
		logic [31:0] d;
		pulse(1);
		@(posedge ref_clk);
		resetn <= 1'b0;
		@(negedge ref_clk);
		`CHK({cpu_run, osc_on, imask, irq_vector}, 19'h7FFFE);
		@(posedge ref_clk);
		resetn <= 1'b1;
		ahb(ADDR_PIN_IRQ_EN, 1'b0, '0, d);
		`CHK(d, 32'h0);
	endtask : t_reset

	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		t_regs();
		t_edges();
		t_prio();
		t_wait();
		t_halt(0);
		t_halt(1);
		t_reset();
		final_report();
	end
endmodule : tb_top
